//--- core/swk_consts.svh
`ifndef SWK_CONSTS_SVH
`define SWK_CONSTS_SVH
// Frame geometry
`define SWK_FRAME_BITS 24
`define SWK_CHAIN_DEVS 2
`define SWK_CHAIN_BITS 48
// Command field: top byte of each frame
`define SWK_CMD_MSB 23
`define SWK_CMD_LSB 16
`define SWK_CMD_STATUS 8'h00
`define SWK_CMD_SLEEP 8'h01
// Wake source flag codes, bits [1:0] of returned status byte
`define SWK_WSRC_NONE 2'h0
`define SWK_WSRC_SWITCH 2'h1
`define SWK_WSRC_SPI 2'h2
`define SWK_WSRC_LINE 2'h3
// Serial clock divider: a half period of the link clock lasts this value plus one clk cycles
`define SWK_SCK_HALF 4'h2
// Host settle wait between two status commands, in microseconds
`define SWK_SETTLE_US 10000
`define SWK_CLK_MHZ 25
`define SWK_SETTLE_CYC (`SWK_SETTLE_US * `SWK_CLK_MHZ)
`endif

//--- core/swk_pkg.sv
package swk_pkg;
  // Operating mode of a device end
  typedef enum logic {
    SWK_NORMAL,
    SWK_SLEEP
  } swk_mode_t;
  // Host sequencer state
  typedef enum logic [2:0] {
    SWK_H_IDLE,
    SWK_H_LOAD,
    SWK_H_LOW,
    SWK_H_HIGH,
    SWK_H_END,
    SWK_H_WAIT
  } swk_hstate_t;
endpackage : swk_pkg

//--- core/swk_link_if.sv
`timescale 1ns/100ps
interface swk_link_if;
  // Serial link, host drives clock, select and data in
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  // Shared open-drain supply-enable line, one enable per device end
  logic wake_n_oe;
  logic wake_n_in;
  modport dev (
    input sck,
    input cs_n,
    input mosi,
    output miso,
    output wake_n_oe,
    input wake_n_in
  );
  modport host (
    output sck,
    output cs_n,
    output mosi,
    input miso,
    input wake_n_in
  );
endinterface : swk_link_if

//--- core/swk_host.sv
`timescale 1ns/100ps
`include "swk_consts.svh"
module swk_host #(
  parameter int SETTLE_CYC = `SWK_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link toward the chain
  swk_link_if.host link,
  // User command port
  input wire logic cmd_valid,
  input wire logic [`SWK_CHAIN_BITS-1:0] cmd_word,
  input wire logic cmd_settle,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [`SWK_CHAIN_BITS-1:0] rsp_word,
  output logic supply_on
);
  import swk_pkg::*;

  typedef struct packed {
    swk_hstate_t st;
    logic [3:0] div;
    logic [5:0] cnt;
    logic [`SWK_CHAIN_BITS-1:0] tx;
    logic [`SWK_CHAIN_BITS-1:0] rx;
    logic settle;
    logic [31:0] wait_cnt;
    logic sck;
    logic cs_n;
    logic mosi;
    logic ready;
    logic rvalid;
    logic [`SWK_CHAIN_BITS-1:0] rword;
    logic miso_s1;
    logic miso_s2;
    logic wk_s1;
    logic wk_s2;
    logic sup;
  } swk_host_t;

  swk_host_t r;
  swk_host_t next_r;

  // Frame sequencer: 48 clocks per chained frame, MSB first
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.miso_s1 = link.miso;
    next_r.miso_s2 = r.miso_s1;
    next_r.wk_s1 = link.wake_n_in;
    next_r.wk_s2 = r.wk_s1;
    next_r.sup = ~r.wk_s2;
    unique case (r.st)
      SWK_H_IDLE: begin
        next_r.ready = 1'b1;
        if (cmd_valid && r.ready) begin
          next_r.ready = 1'b0;
          next_r.tx = cmd_word;
          next_r.settle = cmd_settle;
          next_r.st = SWK_H_LOAD;
        end
      end
      SWK_H_LOAD: begin
        next_r.cs_n = 1'b0;
        next_r.mosi = r.tx[`SWK_CHAIN_BITS-1];
        next_r.cnt = 6'(`SWK_CHAIN_BITS);
        next_r.div = 4'h0;
        next_r.st = SWK_H_LOW;
      end
      SWK_H_LOW: begin
        next_r.div = r.div + 4'h1;
        if (r.div == `SWK_SCK_HALF) begin
          next_r.div = 4'h0;
          next_r.sck = 1'b1;
          next_r.st = SWK_H_HIGH;
        end
      end
      SWK_H_HIGH: begin
        next_r.div = r.div + 4'h1;
        if (r.div == `SWK_SCK_HALF) begin
          // Sample late in the high phase, after the two-stage sync
          next_r.div = 4'h0;
          next_r.sck = 1'b0;
          next_r.rx = {r.rx[`SWK_CHAIN_BITS-2:0], r.miso_s2};
          next_r.tx = {r.tx[`SWK_CHAIN_BITS-2:0], 1'b0};
          next_r.mosi = r.tx[`SWK_CHAIN_BITS-2];
          next_r.cnt = r.cnt - 6'h1;
          next_r.st = (r.cnt == 6'h1) ? SWK_H_END : SWK_H_LOW;
        end
      end
      SWK_H_END: begin
        next_r.cs_n = 1'b1;
        next_r.rvalid = 1'b1;
        next_r.rword = r.rx;
        next_r.wait_cnt = '0;
        next_r.st = r.settle ? SWK_H_WAIT : SWK_H_IDLE;
      end
      SWK_H_WAIT: begin
        // Spacing so woken inputs settle before the next status read
        next_r.wait_cnt = r.wait_cnt + 32'h1;
        if (r.wait_cnt >= 32'(SETTLE_CYC)) begin
          next_r.st = SWK_H_IDLE;
        end
      end
      default: next_r.st = SWK_H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= SWK_H_IDLE;
      r.cs_n <= 1'b1;
      r.wk_s1 <= 1'b1;
      r.wk_s2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.sck = r.sck;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
  assign cmd_ready = r.ready;
  assign rsp_valid = r.rvalid;
  assign rsp_word = r.rword;
  assign supply_on = r.sup;
endmodule : swk_host

//--- core/swk_dev.sv
`timescale 1ns/100ps
`include "swk_consts.svh"
// Behaviour
// - Host clocks 48 bits per two-device frame
// - Sleep command sleeps at chip-select rise
// - Supply enable low in Normal, released Sleep
// - Entering Sleep shows high on supply enable
// - Shared line pulled low wakes other device
// - Switch change during sleep frame blocks sleep
// - Status command in Sleep wakes device
// - Host discards first status after wake; swk_host passes every status on rsp_valid
// - Host waits 10 to 20 ms
// - Host configures before sleep command; no configuration exists here, sleep is sent directly
// - Reset gives Normal Mode, default registers
// - Host rewrites configuration periodically; not done here, there are no configuration registers
// - Switch closure in Sleep wakes, pulls line
// - Wake source flag readable by host
module swk_dev #(
  parameter int NSW = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link toward host and chain
  swk_link_if.dev link,
  // Switch inputs, asynchronous levels
  input wire logic [NSW-1:0] switch_in,
  // Status toward local logic
  output logic sleeping,
  output logic [1:0] wake_src,
  output logic frame_done
);
  import swk_pkg::*;

  typedef struct packed {
    swk_mode_t mode;
    logic [NSW-1:0] sw_s1;
    logic [NSW-1:0] sw_s2;
    logic [NSW-1:0] sw_last;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic mosi_s1;
    logic mosi_s2;
    logic wk_s1;
    logic wk_s2;
    // Cycles spent asleep, saturating at three;
    // gates the line wake just after entry
    logic [1:0] age;
    logic [`SWK_FRAME_BITS-1:0] sh;
    logic [4:0] nbits;
    logic chg_in_frame;
    logic [1:0] src;
    logic miso;
    logic oe;
    logic sleeping;
    logic done;
  } swk_dev_t;

  swk_dev_t r;
  swk_dev_t next_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic sw_change;
  logic [NSW-1:0] sw_diff;
  logic [7:0] cmd;
  logic framed;
  logic sleep_req;
  logic status_req;
  logic line_wake;

  // Edge detects on the second sync stage only
  assign sck_rise = r.sck_s2 & ~r.sck_d;
  assign sck_fall = ~r.sck_s2 & r.sck_d;
  assign cs_fall = ~r.cs_s2 & r.cs_d;
  assign cs_rise = r.cs_s2 & ~r.cs_d;
  assign cmd = r.sh[`SWK_CMD_MSB:`SWK_CMD_LSB];

  // Per-input change flags; any single input counts as an event
  for (genvar g = 0; g < NSW; g++) begin : g_sw
    assign sw_diff[g] = r.sw_s2[g] ^ r.sw_last[g];
  end
  assign sw_change = |sw_diff;

  // Commands count only once a full word has been shifted in
  assign framed = (r.nbits == 5'(`SWK_FRAME_BITS));
  assign sleep_req = framed && (cmd == `SWK_CMD_SLEEP);
  assign status_req = framed && (cmd == `SWK_CMD_STATUS);

  // Own release needs two sync stages to reach wk_s2; until the age
  // counter saturates, a low there is our own stale drive and not a
  // wake from the other end
  assign line_wake = !r.wk_s2 && !r.oe && (r.age == 2'h3);

  // Shift, mode and wake sequencing
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    // Two-stage syncs on every pin; logic reads stage two only
    next_r.sw_s1 = switch_in;
    next_r.sw_s2 = r.sw_s1;
    next_r.sw_last = r.sw_s2;
    next_r.sck_s1 = link.sck;
    next_r.sck_s2 = r.sck_s1;
    next_r.sck_d = r.sck_s2;
    next_r.cs_s1 = link.cs_n;
    next_r.cs_s2 = r.cs_s1;
    next_r.cs_d = r.cs_s2;
    next_r.mosi_s1 = link.mosi;
    next_r.mosi_s2 = r.mosi_s1;
    next_r.wk_s1 = link.wake_n_in;
    next_r.wk_s2 = r.wk_s1;
    if (cs_fall) begin
      // Load status: wake source in low bits, then cleared for next event
      next_r.sh = {`SWK_FRAME_BITS{1'b0}};
      next_r.sh[1:0] = r.src;
      next_r.src = `SWK_WSRC_NONE;
      next_r.nbits = 5'h0;
      next_r.chg_in_frame = 1'b0;
      next_r.miso = 1'b0;
    end
    if (!r.cs_s2) begin
      // 24-bit shift register chains mosi through to miso
      if (sck_rise) begin
        next_r.sh = {r.sh[`SWK_FRAME_BITS-2:0], r.mosi_s2};
        if (r.nbits != 5'(`SWK_FRAME_BITS)) begin
          next_r.nbits = r.nbits + 5'h1;
        end
      end
      // Output moves on the fall so the next end samples it settled
      if (sck_fall) begin
        next_r.miso = r.sh[`SWK_FRAME_BITS-1];
      end
      if (sw_change && r.mode == SWK_NORMAL) begin
        next_r.chg_in_frame = 1'b1;
      end
    end
    if (cs_rise) begin
      // Every end of a chain sees the same select rise and acts on it
      next_r.done = 1'b1;
      if (sleep_req && r.mode == SWK_NORMAL &&
          !r.chg_in_frame && !sw_change) begin
        next_r.mode = SWK_SLEEP;
        next_r.age = 2'h0;
      end
      if (status_req && r.mode == SWK_SLEEP) begin
        next_r.mode = SWK_NORMAL;
        next_r.src = `SWK_WSRC_SPI;
      end
    end

    // Age counter only runs while asleep and never wraps
    if (r.mode == SWK_SLEEP && r.age != 2'h3) begin
      next_r.age = r.age + 2'h1;
    end

    // Wake sources while asleep; switch has priority over the line.
    // Checked even at a select rise, since the change history moves on
    // and an event skipped here would be lost for good.
    if (r.mode == SWK_SLEEP) begin
      if (sw_change) begin
        next_r.mode = SWK_NORMAL;
        next_r.src = `SWK_WSRC_SWITCH;
      end else if (line_wake) begin
        // Only a low driven by another party counts as a wake
        next_r.mode = SWK_NORMAL;
        next_r.src = `SWK_WSRC_LINE;
      end
    end

    // Line driven low for Normal, released high for Sleep
    next_r.oe = (next_r.mode == SWK_NORMAL);
    next_r.sleeping = (next_r.mode == SWK_SLEEP);
  end

  // State register; reset lands in Normal with defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.mode <= SWK_NORMAL;
      r.oe <= 1'b1;
      // Pins that idle high start high, so reset makes no false edge
      // on the select or on the wake line
      r.cs_s1 <= 1'b1;
      r.cs_s2 <= 1'b1;
      r.cs_d <= 1'b1;
      r.wk_s1 <= 1'b1;
      r.wk_s2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Reset also clears switch history, so first sample counts
  assign link.miso = r.miso;
  assign link.wake_n_oe = r.oe;
  assign sleeping = r.sleeping;
  assign wake_src = r.src;
  assign frame_done = r.done;
endmodule : swk_dev

//--- tb/swk_sva.sv
`timescale 1ns/100ps
`include "swk_consts.svh"
module swk_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link and wake line seen by the first device
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wake_n_oe,
  input wire logic wake_n_in
);
  logic sck_q;
  logic [23:0] sh;
  logic [7:0] cmd;
  logic [3:0] since;
  // Last command byte and cycles since the frame closed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      sh <= 24'h000000;
      cmd <= 8'hFF;
      since <= 4'hF;
    end else begin
      sck_q <= sck;
      if (sck && !sck_q) begin
        sh <= {sh[22:0], mosi}; // Data is stable at the clock rise
      end
      if ($rose(cs_n)) begin
        cmd <= sh[`SWK_CMD_MSB:`SWK_CMD_LSB];
        since <= 4'h0;
      end else if (since != 4'hF) begin
        since <= since + 4'h1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Frame closes while this end sleeps
  sequence s_asleep_close;
    !wake_n_oe ##0 $rose(cs_n);
  endsequence
  AST_RST_NORMAL: assert property ($past(rst) |-> wake_n_oe && !miso)
    else $error("not normal after reset");
  AST_SLEEP_CMD: assert property ($fell(wake_n_oe) |->
    cmd == `SWK_CMD_SLEEP)
    else $error("sleep without sleep command");
  AST_SLEEP_AT_CS: assert property ($fell(wake_n_oe) |->
    cs_n && since < 4'h8)
    else $error("sleep away from select rise");
  AST_ENTRY_HIGH: assert property ($fell(wake_n_oe) |=> !wake_n_oe)
    else $error("line not released on sleep");
  AST_LINE_WAKE: assert property (!wake_n_oe && !wake_n_in |->
    ##[1:6] wake_n_oe)
    else $error("low line did not wake");
  AST_SPI_WAKE: assert property (s_asleep_close
    ##0 sh[23:16] == `SWK_CMD_STATUS |-> ##[1:6] wake_n_oe)
    else $error("status frame did not wake");
  AST_FRAME_AWAKE: assert property (!cs_n && wake_n_oe |=> wake_n_oe)
    else $error("slept inside a frame");
  AST_AWAKE_HOLD: assert property (wake_n_oe &&
    cmd != `SWK_CMD_SLEEP |=> wake_n_oe)
    else $error("left normal mode unasked");
endmodule : swk_sva

//--- tb/swk_tb.sv
`timescale 1ns/100ps
`include "swk_consts.svh"
module swk_tb;
  import swk_pkg::*;
  localparam logic [47:0] slp2 = {8'h01, 16'h0000, 8'h01, 16'h0000};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [47:0] cmd_word = 48'h0;
  logic cmd_settle = 1'b0;
  logic cmd_ready, rsp_valid, supply_on;
  logic [47:0] rsp_word;
  logic [21:0] sw0 = 22'h0;
  logic [21:0] sw1 = 22'h0;
  logic slp0, slp1, fd0, fd1;
  logic [1:0] src0, src1;
  int n_fail = 0;
  int n_tests = 0;
  swk_link_if la();
  swk_link_if lb();
  swk_link_if lc();
  // Chain: host to first end, first end to second, second back to host
  assign lb.sck = la.sck;
  assign lc.sck = la.sck;
  assign lb.cs_n = la.cs_n;
  assign lc.cs_n = la.cs_n;
  assign lb.mosi = la.mosi;
  assign lc.mosi = lb.miso;
  assign la.miso = lc.miso;
  // Wired-AND wake line, low while either end pulls
  assign la.wake_n_in = ~(lb.wake_n_oe | lc.wake_n_oe);
  assign lb.wake_n_in = la.wake_n_in;
  assign lc.wake_n_in = la.wake_n_in;
  always #20 clk = ~clk;
  swk_host #(.SETTLE_CYC(20)) i_swk_host (.clk(clk), .rst(rst), .link(la),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_settle(cmd_settle),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .supply_on(supply_on));
  swk_dev i_swk_dev (.clk(clk), .rst(rst), .link(lb), .switch_in(sw0),
    .sleeping(slp0), .wake_src(src0), .frame_done(fd0));
  swk_dev i_swk_dev_1 (.clk(clk), .rst(rst), .link(lc), .switch_in(sw1),
    .sleeping(slp1), .wake_src(src1), .frame_done(fd1));
  swk_sva i_swk_sva (.clk(clk), .rst(rst), .sck(lb.sck), .cs_n(lb.cs_n),
    .mosi(lb.mosi), .miso(lb.miso), .wake_n_oe(lb.wake_n_oe),
    .wake_n_in(lb.wake_n_in));
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Mode and wake source of both ends plus the supply enable
  task state(input logic [6:0] exp);
    chk({41'h0, slp1, slp0, src1, src0, supply_on}, {41'h0, exp});
  endtask : state
  // One command frame; hold valid until taken, then wait for the answer
  task send(input logic [47:0] w, input logic st);
    int i;
    i = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_word = w;
    cmd_settle = st;
    while (cmd_ready !== 1'b1 && i < 500) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 3000) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 500) begin
      n_fail++;
      wrap_up;
    end
    repeat (12) @(negedge clk); // Ends act after synchronising
  endtask : send
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    state(7'h01);
    send(slp2, 1'b0);
    state(7'h60);
    sw1[3] = 1'b1;
    repeat (12) @(negedge clk);
    state(7'h0F);
    send(slp2, 1'b0);
    state(7'h60);
    send(48'h0, 1'b1);
    state(7'h15);
    send(48'h0, 1'b1);
    state(7'h01);
    // Switch moves while the sleep frame is still selected
    fork
      send(slp2, 1'b0);
      begin
        int j;
        j = 0;
        while (la.cs_n !== 1'b0 && j < 100) begin
          @(negedge clk);
          j++;
        end
        if (j >= 100) n_fail++;
        repeat (20) @(negedge clk);
        sw0[5] = 1'b1;
      end
    join
    state(7'h19);
    send(slp2, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    state(7'h01);
    send(48'h0, 1'b0);
    state(7'h01);
    wrap_up;
  end
endmodule : swk_tb
